// file: design/fcg_consts.svh
// Offsets, field positions, reset values and timing counts of the generator
`ifndef FCG_CONSTS_SVH
`define FCG_CONSTS_SVH
`define FCG_OFS_CTRL1 8'h00
`define FCG_OFS_CTRL2 8'h04
`define FCG_OFS_STAT1 8'h08
`define FCG_OFS_STAT2 8'h0c
`define FCG_OFS_TRIM 8'h10
`define FCG_OFS_MASK 8'h14
`define FCG_OFS_FILT 8'h18
`define FCG_B_HIGAIN 7
`define FCG_B_RANGE 6
`define FCG_B_REFSEL 5
`define FCG_B_KEEP 2
`define FCG_B_LOCDIS 1
`define FCG_B_LOLRST 7
`define FCG_B_LOCRST 3
`define FCG_S1_LOL 3
`define FCG_S1_LOC 2
`define FCG_S1_LOCK 1
`define FCG_S1_IRQ 0
`define FCG_S2_STABLE 0
`define FCG_CTRL1_RST 8'h00
`define FCG_CTRL2_RST 8'h00
`define FCG_TRIM_RST 8'h80
`define FCG_MASK_RST 8'h00
`define FCG_SELF_DCO_KHZ 24'h1f40
`define FCG_SELF_BUS_KHZ 24'h0fa0
`define FCG_IRG_NOM_KHZ 24'h00f3
`define FCG_TRIM_MID 24'h0080
`define FCG_PRESCALE_HI 7'h01
`define FCG_PRESCALE_LO 7'h40
`define FCG_INT_PRESCALE 40'h40
`define FCG_INT_DIVISOR 40'h7
`define FCG_FLL_STEP_KHZ 24'h0040
`define FCG_CLK_PERIOD_NS 8
`define FCG_LOC_TIMEOUT_NS 2000
`define FCG_LOC_TIMEOUT_CYC \
  ((`FCG_LOC_TIMEOUT_NS + `FCG_CLK_PERIOD_NS - 1) / `FCG_CLK_PERIOD_NS)
`endif

// file: design/fcg_pkg.sv
// Types shared by the clock generator modules
package fcg_pkg;
  typedef enum logic [1:0] {
    fcg_self_clocked_mode,
    fcg_loop_engaged_internal_mode,
    fcg_bypassed_external_mode,
    fcg_loop_engaged_external_mode
  } fcg_scheme_t;
  typedef enum logic [1:0] {
    fcg_fll_hold,
    fcg_fll_acquire,
    fcg_fll_locked
  } fcg_fll_state_t;
endpackage

// file: design/fcg_loop_if.sv
// Signals between the register block, the loop and the clock monitor
interface fcg_loop_if;
  logic engaged;
  logic [23:0] target_khz;
  logic [23:0] hold_khz;
  logic [23:0] flt_khz;
  logic locked;
  logic watch;
  logic ref_tick;
  logic ref_lost;
  modport ctl (output engaged, target_khz, hold_khz, watch, ref_tick,
               input flt_khz, locked, ref_lost);
  modport fll (input engaged, target_khz, hold_khz,
               output flt_khz, locked);
  modport mon (input watch, ref_tick, output ref_lost);
endinterface

// file: design/fcg_fll.sv
// Closed-loop filter that walks the oscillator toward its target
`include "fcg_consts.svh"
module fcg_fll #(
  parameter logic [23:0] STEP_KHZ = `FCG_FLL_STEP_KHZ
) (
  input wire logic core_clk,
  input wire logic resetn,
  fcg_loop_if.fll lp
);
  fcg_pkg::fcg_fll_state_t state_r, state_nxt;
  logic [23:0] flt_r, flt_nxt;
  wire up = lp.target_khz > flt_r;
  wire [23:0] gap = up ? lp.target_khz - flt_r : flt_r - lp.target_khz;
  wire near = gap <= STEP_KHZ;

  always_comb begin
    flt_nxt = lp.hold_khz;
    state_nxt = fcg_pkg::fcg_fll_hold;
    if (lp.engaged && near) begin
      flt_nxt = lp.target_khz;
      state_nxt = fcg_pkg::fcg_fll_locked;
    end else if (lp.engaged) begin
      // Bounded steps keep the output from jumping past the target
      flt_nxt = up ? flt_r + STEP_KHZ : flt_r - STEP_KHZ;
      state_nxt = fcg_pkg::fcg_fll_acquire;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      flt_r <= `FCG_SELF_DCO_KHZ;
      state_r <= fcg_pkg::fcg_fll_hold;
    end else begin
      flt_r <= flt_nxt;
      state_r <= state_nxt;
    end
  end

  assign lp.flt_khz = flt_r;
  assign lp.locked = state_r == fcg_pkg::fcg_fll_locked;
endmodule

// file: design/fcg_locmon.sv
// Watchdog on the external reference ticks
`include "fcg_consts.svh"
module fcg_locmon #(
  parameter int unsigned TIMEOUT = `FCG_LOC_TIMEOUT_CYC
) (
  input wire logic core_clk,
  input wire logic resetn,
  fcg_loop_if.mon lp
);
  logic [15:0] count_r;
  logic lost_r;
  wire expire = count_r == 16'(TIMEOUT - 1);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      count_r <= 16'h0000;
      lost_r <= 1'b0;
    end else if (!lp.watch || lp.ref_tick) begin
      count_r <= 16'h0000;
      lost_r <= 1'b0;
    end else if (expire) begin
      lost_r <= 1'b1;
    end else begin
      count_r <= count_r + 16'h0001;
    end
  end

  assign lp.ref_lost = lost_r;
endmodule

// file: design/fcg_clock_generator_config.sv
// Clock generator configuration: registers, loop control and events
//==============================================================
// Overview of operation
// - Reset gives self-clocked 8 MHz, bus 4 MHz
// - Range one: high range, prescale one
// - Range zero: low range, prescale sixty-four
// - Scheme 11: loop engaged on external reference
// - Scheme 01: loop engaged on internal reference
// - Multiply code 011 gives factor ten
// - Divide code 000 is one, 001 two
// - Loss-of-clock disable zero keeps detection active in the external schemes (10, 11)
// - Lock loss interrupts unless its reset enabled
// - Clock loss interrupts unless its reset enabled
// - High gain zero selects low power oscillator
// - Reference select requests crystal; ignored internally
// - Control one bit zero always reads zero
// - Status one read-only except flag clearing
// - Status two read-only, shows oscillator stable
// - Trim register eight bits tunes internal reference
`include "fcg_consts.svh"
module fcg_clock_generator_config #(
  parameter int unsigned LOC_TIMEOUT = `FCG_LOC_TIMEOUT_CYC,
  parameter logic [23:0] FLL_STEP = `FCG_FLL_STEP_KHZ
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic ext_ref_tick,
  input wire logic [23:0] ext_ref_khz,
  output logic osc_high_gain,
  output logic osc_high_range,
  output logic osc_request,
  output logic osc_keep_on,
  output logic loc_detect_on,
  output logic [6:0] ref_prescale,
  output logic [4:0] mult_factor,
  output logic [7:0] div_factor,
  output logic [1:0] scheme,
  output logic [23:0] gen_clk_khz,
  output logic [23:0] bus_clk_khz,
  output logic loop_locked,
  output logic osc_stable,
  output logic clock_reset_req,
  output logic irq
);
  //==============================================================
  // Decode helpers
  function automatic logic [4:0] mult_of(input logic [2:0] code);
    mult_of = 5'h04 + {1'b0, code, 1'b0};
  endfunction

  function automatic logic [6:0] prescale_of(input logic range);
    prescale_of = range ? `FCG_PRESCALE_HI : `FCG_PRESCALE_LO;
  endfunction

  function automatic logic [23:0] clamp24(input logic [39:0] v);
    clamp24 = (v > 40'h00_00ff_ffff) ? 24'hff_ffff : v[23:0];
  endfunction

  //==============================================================
  // Bus slave, zero wait states
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic [31:0] hrdata_r;
  logic hreadyout_r;
  logic hresp_r;
  logic [31:0] rd_nxt;
  wire take = hsel && htrans[1] && hready;
  wire rd_take = take && !hwrite;
  wire wr_take = take && hwrite;
  wire [7:0] a_ofs = haddr[7:0];
  wire a_hit = haddr[31:8] == 24'h00_0000;
  wire [7:0] wdat = hwdata[7:0];

  wire wr_c1 = wr_pend_r && wr_addr_r == `FCG_OFS_CTRL1;
  wire wr_c2 = wr_pend_r && wr_addr_r == `FCG_OFS_CTRL2;
  wire wr_s1 = wr_pend_r && wr_addr_r == `FCG_OFS_STAT1;
  wire wr_tr = wr_pend_r && wr_addr_r == `FCG_OFS_TRIM;
  wire wr_mk = wr_pend_r && wr_addr_r == `FCG_OFS_MASK;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= wr_take && a_hit;
      wr_addr_r <= a_ofs;
    end
  end

  //==============================================================
  // Software registers
  logic [7:0] ctrl1_r, ctrl1_nxt;
  logic [7:0] ctrl2_r, ctrl2_nxt;
  logic [7:0] trim_r, trim_nxt;
  logic [7:0] mask_r, mask_nxt;
  logic lol_flag_r, lol_flag_nxt;
  logic loc_flag_r, loc_flag_nxt;
  logic lol_set, loc_set;

  // Bit zero of control one has no storage behind it
  assign ctrl1_nxt = wr_c1 ? {wdat[7:1], 1'b0} : ctrl1_r;
  assign ctrl2_nxt = wr_c2 ? wdat : ctrl2_r;
  assign trim_nxt = wr_tr ? wdat : trim_r;
  assign mask_nxt = wr_mk ? (wdat & 8'h0c) : mask_r;

  // A write can only clear flags, and a new event wins over the clear
  wire clr_lol = wr_s1 && wdat[`FCG_S1_LOL];
  wire clr_loc = wr_s1 && wdat[`FCG_S1_LOC];
  assign lol_flag_nxt = lol_set || (lol_flag_r && !clr_lol);
  assign loc_flag_nxt = loc_set || (loc_flag_r && !clr_loc);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl1_r <= `FCG_CTRL1_RST;
      ctrl2_r <= `FCG_CTRL2_RST;
      trim_r <= `FCG_TRIM_RST;
      mask_r <= `FCG_MASK_RST;
      lol_flag_r <= 1'b0;
      loc_flag_r <= 1'b0;
    end else begin
      ctrl1_r <= ctrl1_nxt;
      ctrl2_r <= ctrl2_nxt;
      trim_r <= trim_nxt;
      mask_r <= mask_nxt;
      lol_flag_r <= lol_flag_nxt;
      loc_flag_r <= loc_flag_nxt;
    end
  end

  //==============================================================
  // Field decode
  wire high_gain = ctrl1_r[`FCG_B_HIGAIN];
  wire range_hi = ctrl1_r[`FCG_B_RANGE];
  wire ref_sel = ctrl1_r[`FCG_B_REFSEL];
  wire [1:0] scheme_sel = ctrl1_r[4:3];
  wire keep_on = ctrl1_r[`FCG_B_KEEP];
  wire loc_dis = ctrl1_r[`FCG_B_LOCDIS];
  wire lol_rst_en = ctrl2_r[`FCG_B_LOLRST];
  wire loc_rst_en = ctrl2_r[`FCG_B_LOCRST];
  wire [2:0] mult_code = ctrl2_r[6:4];
  wire [2:0] div_code = ctrl2_r[2:0];

  fcg_pkg::fcg_scheme_t mode;
  assign mode = fcg_pkg::fcg_scheme_t'(scheme_sel);
  wire is_ext_loop = mode == fcg_pkg::fcg_loop_engaged_external_mode;
  wire is_int_loop = mode == fcg_pkg::fcg_loop_engaged_internal_mode;
  wire is_fbe = mode == fcg_pkg::fcg_bypassed_external_mode;
  wire engaged = is_ext_loop || is_int_loop;
  wire uses_ext = is_ext_loop || is_fbe;

  wire [6:0] pre = prescale_of(range_hi);
  wire [4:0] nf = mult_of(mult_code);

  //==============================================================
  // Target frequency of the oscillator
  // Trim moves the internal reference one kHz per code around mid-scale
  wire [23:0] irg_khz = `FCG_IRG_NOM_KHZ + {16'h0000, trim_r} -
                        `FCG_TRIM_MID;
  wire [39:0] ext_prod = 40'(ext_ref_khz) * 40'(pre) * 40'(nf);
  wire [39:0] int_prod = 40'(irg_khz) * `FCG_INT_PRESCALE * 40'(nf) /
                         `FCG_INT_DIVISOR;
  wire [23:0] target = is_ext_loop ? clamp24(ext_prod) : clamp24(int_prod);

  //==============================================================
  // Loop and reference monitor
  fcg_loop_if lp ();
  assign lp.engaged = engaged;
  assign lp.target_khz = target;
  assign lp.hold_khz = `FCG_SELF_DCO_KHZ;
  assign lp.watch = uses_ext && !loc_dis;
  assign lp.ref_tick = ext_ref_tick;

  fcg_fll #(
    .STEP_KHZ(FLL_STEP)
  ) u_fll (
    .core_clk(core_clk),
    .resetn(resetn),
    .lp(lp.fll)
  );

  fcg_locmon #(
    .TIMEOUT(LOC_TIMEOUT)
  ) u_locmon (
    .core_clk(core_clk),
    .resetn(resetn),
    .lp(lp.mon)
  );

  //==============================================================
  // Events, flags and the interrupt
  logic locked_d_r;
  logic lost_d_r;
  logic rst_req_r;
  logic irq_r;
  wire lol_evt = engaged && locked_d_r && !lp.locked;
  wire loc_evt = lp.ref_lost && !lost_d_r;
  // Either event goes to the flag or to the reset request, never both
  assign lol_set = lol_evt && !lol_rst_en;
  assign loc_set = loc_evt && !loc_rst_en;
  wire rst_req_nxt = (lol_evt && lol_rst_en) ||
                     (loc_evt && loc_rst_en);
  wire irq_nxt = (lol_flag_nxt && mask_nxt[`FCG_S1_LOL]) ||
                 (loc_flag_nxt && mask_nxt[`FCG_S1_LOC]);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      locked_d_r <= 1'b0;
      lost_d_r <= 1'b0;
      rst_req_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      locked_d_r <= lp.locked;
      lost_d_r <= lp.ref_lost;
      rst_req_r <= rst_req_nxt;
      irq_r <= irq_nxt;
    end
  end

  //==============================================================
  // Output clock estimate
  logic [23:0] gen_khz_r;
  logic [23:0] bus_khz_r;
  logic stable_r;
  // Bypassed external passes the reference straight to the divider
  wire [23:0] dco_src = is_fbe ? ext_ref_khz : lp.flt_khz;
  wire [23:0] gen_nxt = dco_src >> div_code;
  wire stable_nxt = engaged ? lp.locked : 1'b1;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      gen_khz_r <= `FCG_SELF_DCO_KHZ;
      bus_khz_r <= `FCG_SELF_BUS_KHZ;
      stable_r <= 1'b1;
    end else begin
      gen_khz_r <= gen_nxt;
      bus_khz_r <= {1'b0, gen_nxt[23:1]};
      stable_r <= stable_nxt;
    end
  end

  //==============================================================
  // Read back, taken from next-state values so a read straight after
  // a write returns the new contents
  wire [7:0] stat1_v = {4'h0, lol_flag_nxt, loc_flag_nxt,
                        lp.locked, irq_nxt};
  wire [7:0] stat2_v = {7'h00, stable_nxt};

  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (rd_take && a_hit) begin
      unique case (a_ofs)
        `FCG_OFS_CTRL1: rd_nxt[7:0] = ctrl1_nxt;
        `FCG_OFS_CTRL2: rd_nxt[7:0] = ctrl2_nxt;
        `FCG_OFS_STAT1: rd_nxt[7:0] = stat1_v;
        `FCG_OFS_STAT2: rd_nxt[7:0] = stat2_v;
        `FCG_OFS_TRIM: rd_nxt[7:0] = trim_nxt;
        `FCG_OFS_MASK: rd_nxt[7:0] = mask_nxt;
        `FCG_OFS_FILT: rd_nxt[23:0] = lp.flt_khz;
        default: rd_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      hrdata_r <= 32'h0000_0000;
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
    end else begin
      hrdata_r <= rd_nxt;
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
    end
  end

  //==============================================================
  // Oscillator and divider controls
  logic high_gain_r;
  logic range_r;
  logic req_r;
  logic keep_r;
  logic locdet_r;
  logic [6:0] pre_r;
  logic [4:0] nf_r;
  logic [7:0] rdiv_r;
  logic [1:0] mode_r;
  logic lock_r;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      high_gain_r <= 1'b0;
      range_r <= 1'b0;
      req_r <= 1'b0;
      keep_r <= 1'b0;
      locdet_r <= 1'b0;
      pre_r <= `FCG_PRESCALE_LO;
      nf_r <= 5'h04;
      rdiv_r <= 8'h01;
      mode_r <= 2'b00;
      lock_r <= 1'b0;
    end else begin
      high_gain_r <= high_gain;
      range_r <= range_hi;
      req_r <= ref_sel && !is_int_loop;
      keep_r <= keep_on;
      locdet_r <= lp.watch;
      pre_r <= pre;
      nf_r <= nf;
      rdiv_r <= 8'h01 << div_code;
      mode_r <= scheme_sel;
      lock_r <= lp.locked;
    end
  end

  assign hrdata = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp = hresp_r;
  assign osc_high_gain = high_gain_r;
  assign osc_high_range = range_r;
  assign osc_request = req_r;
  assign osc_keep_on = keep_r;
  assign loc_detect_on = locdet_r;
  assign ref_prescale = pre_r;
  assign mult_factor = nf_r;
  assign div_factor = rdiv_r;
  assign scheme = mode_r;
  assign gen_clk_khz = gen_khz_r;
  assign bus_clk_khz = bus_khz_r;
  assign loop_locked = lock_r;
  assign osc_stable = stable_r;
  assign clock_reset_req = rst_req_r;
  assign irq = irq_r;
endmodule

// file: verification/fcg_cfg_props.sv
// Port-level assertions for the clock generator configuration
`include "fcg_consts.svh"
module fcg_cfg_props #(
  parameter int unsigned LOC_TIMEOUT = 250,
  parameter logic [23:0] FLL_STEP = 24'h00_0040
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic osc_high_gain,
  input wire logic osc_high_range,
  input wire logic osc_request,
  input wire logic loc_detect_on,
  input wire logic [6:0] ref_prescale,
  input wire logic [4:0] mult_factor,
  input wire logic [7:0] div_factor,
  input wire logic [1:0] scheme,
  input wire logic [23:0] gen_clk_khz,
  input wire logic [23:0] bus_clk_khz,
  input wire logic osc_stable,
  input wire logic clock_reset_req
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  //==============================================================
  // Data phase tracking
  logic dp_wr_r, dp_rd_r;
  logic [7:0] dp_ofs_r;
  wire take = hsel & htrans[1] & hready;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      dp_wr_r <= 1'b0;
      dp_rd_r <= 1'b0;
      dp_ofs_r <= 8'h00;
    end else if (hready) begin
      dp_wr_r <= take & hwrite;
      dp_rd_r <= take & ~hwrite;
      dp_ofs_r <= haddr[7:0];
    end
  end
  wire wr1 = dp_wr_r && dp_ofs_r == `FCG_OFS_CTRL1;
  wire wr2 = dp_wr_r && dp_ofs_r == `FCG_OFS_CTRL2;
  //==============================================================
  // Assertions
  reset_state_a: assert property ($rose(resetn) |->
    gen_clk_khz == 24'h00_1f40 && bus_clk_khz == 24'h00_0fa0 && scheme == 0)
    else $error("reset state wrong");
  prescale_sel_a: assert property (
    ref_prescale == (osc_high_range ? 7'h01 : 7'h40))
    else $error("prescale mismatch");
  scheme_wr_a: assert property (wr1 |-> ##2
    scheme == $past(hwdata[4:3], 2) && osc_high_range == $past(hwdata[6], 2)
    && osc_high_gain == $past(hwdata[7], 2)) else $error("ctrl1 fields");
  request_wr_a: assert property (wr1 |-> ##2 osc_request ==
    ($past(hwdata[5], 2) && $past(hwdata[4:3], 2) != 2'b01))
    else $error("request wrong");
  loc_watch_a: assert property (wr1 |-> ##2 loc_detect_on ==
    ($past(hwdata[4], 2) && !$past(hwdata[1], 2))) else $error("watch");
  factor_wr_a: assert property (wr2 |-> ##2
    mult_factor == 5'h04 + {$past(hwdata[6:4], 2), 1'b0} &&
    div_factor == 8'h01 << $past(hwdata[2:0], 2)) else $error("factors");
  bus_half_a: assert property (bus_clk_khz == gen_clk_khz >> 1)
    else $error("bus clock not half");
  bit0_zero_a: assert property (dp_rd_r && dp_ofs_r == 8'h00 |->
    hrdata[0] == 1'b0) else $error("ctrl1 bit0 set");
  stable_rd_a: assert property (dp_rd_r && dp_ofs_r == 8'h0c |->
    hrdata == {31'h0, osc_stable}) else $error("status2 read");
  req_pulse_a: assert property (clock_reset_req |=> !clock_reset_req)
    else $error("reset request too long");
endmodule
bind fcg_clock_generator_config fcg_cfg_props #(.LOC_TIMEOUT(LOC_TIMEOUT),
  .FLL_STEP(FLL_STEP)) i_fcg_cfg_props (.core_clk, .resetn, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .hrdata, .osc_high_gain,
  .osc_high_range, .osc_request, .loc_detect_on, .ref_prescale,
  .mult_factor, .div_factor, .scheme, .gen_clk_khz, .bus_clk_khz,
  .osc_stable, .clock_reset_req);

// file: verification/fcg_ref_src.sv
// Model of the external reference source feeding the generator
module fcg_ref_src #(
  parameter int unsigned PERIOD = 4,
  parameter logic [23:0] KHZ = 24'h00_0fa0
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic run,
  output logic tick,
  output logic [23:0] khz
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_r;
  // A stopped source gives no ticks at all, as a dead crystal would
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) cnt_r <= 8'h00;
    else if (!run || cnt_r == 8'(PERIOD - 1)) cnt_r <= 8'h00;
    else cnt_r <= cnt_r + 8'h01;
  end
  assign tick = run && cnt_r == 8'(PERIOD - 1);
  assign khz = KHZ;
endmodule

// file: verification/fcg_clock_generator_config_tb_top.sv
// Self-checking bench for the clock generator configuration
`include "fcg_consts.svh"
module fcg_clock_generator_config_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic ref_run = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010;
  logic [31:0] haddr = '0;
  logic [31:0] hwdata = '0;
  logic hreadyout, hresp, ext_ref_tick, osc_high_gain, osc_high_range;
  logic osc_request, osc_keep_on, loc_detect_on, loop_locked, osc_stable;
  logic clock_reset_req, irq;
  logic [31:0] hrdata;
  logic [23:0] ext_ref_khz, gen_clk_khz, bus_clk_khz;
  logic [6:0] ref_prescale;
  logic [4:0] mult_factor;
  logic [7:0] div_factor;
  logic [1:0] scheme;
  int n_errors = 0;
  int checked = 0;
  logic [7:0] ofs_t [6] = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h0c, 8'h40};
  logic [31:0] rst_t [6] = '{32'h0, 32'h0, 32'h80, 32'h0, 32'h1, 32'h0};
  always #4 core_clk = ~core_clk;
  fcg_clock_generator_config #(.LOC_TIMEOUT(8)) i_fcg_clock_generator_config (
    .core_clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .ext_ref_tick,
    .ext_ref_khz, .osc_high_gain, .osc_high_range, .osc_request,
    .osc_keep_on, .loc_detect_on, .ref_prescale, .mult_factor, .div_factor,
    .scheme, .gen_clk_khz, .bus_clk_khz, .loop_locked, .osc_stable,
    .clock_reset_req, .irq);
  fcg_ref_src i_fcg_ref_src (.core_clk, .resetn, .run(ref_run),
    .tick(ext_ref_tick), .khz(ext_ref_khz));
  //==============================================================
  // Bus and compare tasks
  task automatic results();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic edge_rdy();
    int i;
    i = 0;
    do begin
      @(posedge core_clk);
      i++;
    end while (hreadyout !== 1'b1 && i < 64);
    if (hreadyout !== 1'b1) begin
      n_errors++;
      results();
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] ofs,
                      input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h00_0000, ofs};
    edge_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    edge_rdy();
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, ofs, d, x);
  endtask
  task automatic rd_chk(input logic [7:0] ofs, input logic [31:0] e,
                        input logic [31:0] m = 32'hffff_ffff);
    logic [31:0] x;
    xfer(1'b0, ofs, 32'h0, x);
    chk(x & m, e);
  endtask
  // Waits on locked, irq or reset request, with a bound
  task automatic wait_hi(input int sel);
    logic s;
    for (int i = 0; i < 4000; i++) begin
      @(posedge core_clk);
      s = sel == 0 ? loop_locked : sel == 1 ? irq : clock_reset_req;
      if (s === 1'b1) return;
    end
    n_errors++;
    results();
  endtask
  function automatic logic near(input logic [23:0] g, input logic [23:0] e);
    return (g > e ? g - e : e - g) <= 24'h00_0040;
  endfunction
  //==============================================================
  // Scenarios
  initial begin
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    chk(32'(gen_clk_khz), 32'h0000_1f40);
    chk(32'(bus_clk_khz), 32'h0000_0fa0);
    chk(32'(ref_prescale), 32'h0000_0040);
    chk(32'(hresp), 32'h0000_0000);
    for (int i = 0; i < 6; i++) rd_chk(ofs_t[i], rst_t[i]);
    ref_run <= 1'b1;
    wr(`FCG_OFS_CTRL1, 32'h0000_0079);
    rd_chk(`FCG_OFS_CTRL1, 32'h0000_0078);
    wr(`FCG_OFS_CTRL2, 32'h0000_0030);
    repeat (2) @(posedge core_clk);
    chk(32'({scheme, ref_prescale, mult_factor, div_factor, osc_request,
      loc_detect_on}), 32'({2'b11, 7'h01, 5'h0a, 8'h01, 2'b11}));
    wait_hi(0);
    chk(32'(near(gen_clk_khz, 24'h00_9c40)), 32'h1);
    chk(32'(near(bus_clk_khz, 24'h00_4e20)), 32'h1);
    rd_chk(`FCG_OFS_STAT2, 32'h1);
    wr(`FCG_OFS_CTRL2, 32'h0000_0031);
    repeat (3) @(posedge core_clk);
    wait_hi(0);
    chk(32'(near(gen_clk_khz, 24'h00_4e20)), 32'h1);
    // Lock loss from a new multiply code, flagged not reset
    wr(`FCG_OFS_MASK, 32'h0000_000c);
    wr(`FCG_OFS_CTRL2, 32'h0000_0041);
    wait_hi(1);
    rd_chk(`FCG_OFS_STAT1, 32'h8, 32'h8);
    // Still acquiring the new target, so not yet stable
    rd_chk(`FCG_OFS_STAT2, 32'h0);
    chk(32'(osc_stable), 32'h0);
    wr(`FCG_OFS_STAT1, 32'h0000_000b);
    rd_chk(`FCG_OFS_STAT1, 32'h0, 32'hc);
    wait_hi(0);
    ref_run <= 1'b0;
    wait_hi(1);
    rd_chk(`FCG_OFS_STAT1, 32'h4, 32'h4);
    ref_run <= 1'b1;
    wait_hi(0);
    wr(`FCG_OFS_STAT1, 32'h0000_000c);
    repeat (2) @(posedge core_clk);
    chk(32'(irq), 32'h0);
    // Both reset enables set: a lost clock asks for reset only
    wr(`FCG_OFS_CTRL2, 32'h0000_00c9);
    ref_run <= 1'b0;
    wait_hi(2);
    ref_run <= 1'b1;
    rd_chk(`FCG_OFS_STAT1, 32'h0, 32'h4);
    wr(`FCG_OFS_CTRL1, 32'h0000_00fe);
    repeat (2) @(posedge core_clk);
    chk(32'({osc_high_gain, osc_keep_on, loc_detect_on}), 32'h6);
    wr(`FCG_OFS_CTRL1, 32'h0000_0028);
    repeat (2) @(posedge core_clk);
    chk(32'({scheme, osc_request, ref_prescale}), 32'h0000_0140);
    // Trim with twice the final divisor, then restore it
    wr(`FCG_OFS_CTRL2, 32'h0000_0042);
    wr(`FCG_OFS_TRIM, 32'h0000_005a);
    rd_chk(`FCG_OFS_TRIM, 32'h0000_005a);
    wait_hi(0);
    wr(`FCG_OFS_CTRL2, 32'h0000_0041);
    repeat (2) @(posedge core_clk);
    chk(32'(near(gen_clk_khz, 24'h00_2bed)), 32'h1);
    // Bypassed external: reference goes straight to the divider
    wr(`FCG_OFS_CTRL1, 32'h0000_0010);
    repeat (2) @(posedge core_clk);
    chk(32'(gen_clk_khz), 32'h0000_07d0);
    wr(8'h40, 32'h0000_00ff);
    rd_chk(8'h40, 32'h0);
    results();
  end
endmodule
